// *** trigger_acq_and_wake_source_config.sv ***
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// (R1) An 8-bit read/write register at 0x18 holds trigger mode, three wake enables, pulse select, pin function, drive and polarity.
// (R2) With trigger mode 0 each rising trigger edge makes one conversion and the result is stored once the decimation count is reached.
// (R3) With trigger mode 1 each rising trigger edge runs a full burst of decimation-count conversions and then stores the result.
// (R4) Trigger mode applies only while the second interrupt pin is set to act as trigger input.
// (R5) Data ready rises only after all conversions are done and the decimated result is available.
// (R6) Data ready is raised in trigger mode only while buffer mode is 00b.
// (R7) In low-power mode trigger mode is ignored because decimation is fixed at 1.
// (R8) With the within-threshold wake enable set, a change detector within-threshold event blocks sleep entry and forces exit.
// (R9) Decimation follows the data rate in high-performance mode and a four-bit field in flexible mode; low-power mode fixes it at 1.
// (R10) The trigger input is synchronised and its rising edges become single-cycle events.
module trigger_acq_and_wake_source_config
	import trig_acq_pkg::*;
#(
	parameter int CONV_CYCLES = CONV_CYCLES_DEF
)
(
	input wire logic clock,
	input wire logic rst,
	input wire logic wb_cyc,
	input wire logic wb_stb,
	input wire logic wb_we,
	input wire logic [7:0] wb_adr,
	input wire logic [3:0] wb_sel,
	input wire logic [31:0] wb_dat_w,
	output logic [31:0] wb_dat_r,
	output logic wb_ack,
	input wire logic trig_pin,
	input wire logic [11:0] adc_sample,
	input wire logic within_thresh_event,
	input wire logic sleep_request,
	input wire logic wake_request,
	output logic [7:0] config_out,
	output logic [11:0] axis_result,
	output logic data_ready_flag,
	output logic buf_wr,
	output logic [11:0] buf_data,
	output logic sleep_state,
	output logic conv_busy
);
	logic [7:0] cfg_q;
	logic [15:0] ctrl_q;
	logic ack_q;
	logic [31:0] dat_r_q;
	acq_state_type state_q;
	logic [CONV_CNT_W-1:0] conv_cnt_q;
	logic [DEC_CNT_W-1:0] taken_q;
	logic [ACC_W-1:0] acc_q;
	logic [11:0] result_q;
	logic drdy_q;
	logic buf_wr_q;
	logic [11:0] buf_data_q;
	logic sleep_q;
	logic trig_rise;
	logic [1:0] pm;
	logic [1:0] buf_mode;
	logic [3:0] dec_log;
	logic [DEC_CNT_W-1:0] dec_count;
	logic [DEC_CNT_W-1:0] taken_next;
	logic [ACC_W-1:0] acc_next;
	logic req;
	logic wr_s;
	logic rd_result_s;
	logic trig_en;
	logic burst;
	logic conv_done;
	logic store_s;

	////////////////////////////////////////////////////////////////////////
	trig_edge_sync u_sync
	(
		.clock(clock),
		.rst(rst),
		.trig_pin(trig_pin),
		.trig_rise(trig_rise)
	);

	function automatic logic [3:0] dec_log_of(input logic [1:0] mode,
		input logic [3:0] odr, input logic [3:0] fdec);
		logic [3:0] sel;
		sel = 4'h0;
		case (mode)
			PM_HIGH: sel = odr;
			PM_FLEX: sel = fdec;
			default: sel = 4'h0;
		endcase
		// codes past 12 all mean the longest decimation
		if (sel > DEC_LOG_MAX)
			sel = DEC_LOG_MAX;
		return sel;
	endfunction : dec_log_of

	assign pm = ctrl_q[PM_LO +: 2];
	assign buf_mode = ctrl_q[BUF_MODE_LO +: 2];
	assign dec_log = dec_log_of(pm, ctrl_q[ODR_LO +: 4],
		ctrl_q[FLEX_DEC_LO +: 4]); // see (R9)
	assign dec_count = DEC_CNT_W'(1) << dec_log;
	assign trig_en = cfg_q[IRQ2_FUNC_BIT]; // see (R4)
	assign burst = cfg_q[TRIG_ACQ_MODE_BIT] & (pm != PM_LOW); // see (R7)

	////////////////////////////////////////////////////////////////////////
	// wishbone slave: one wait state, unmapped reads return zero
	assign req = wb_cyc & wb_stb & ~ack_q;
	assign wr_s = req & wb_we;
	assign rd_result_s = req & ~wb_we & (wb_adr == RESULT_ADDR);

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			ack_q <= 1'b0;
		else
			ack_q <= req;
	end

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			dat_r_q <= 32'h0000_0000;
		else if (req)
		begin
			case (wb_adr)
				CTRL_ADDR: dat_r_q <= {16'h0000, ctrl_q};
				STATUS_ADDR: dat_r_q <= {29'h0000_0000, state_q == ST_CONV,
					sleep_q, drdy_q};
				RESULT_ADDR: dat_r_q <= {20'h0_0000, result_q};
				CFG4_ADDR: dat_r_q <= {24'h00_0000, cfg_q};
				default: dat_r_q <= 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			cfg_q <= CFG4_RESET;
		else if (wr_s && wb_adr == CFG4_ADDR && wb_sel[0])
			cfg_q <= wb_dat_w[7:0]; // see (R1)
	end

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			ctrl_q <= CTRL_RESET;
		else if (wr_s && wb_adr == CTRL_ADDR)
		begin
			if (wb_sel[0])
				ctrl_q[7:0] <= wb_dat_w[7:0];
			if (wb_sel[1])
				ctrl_q[15:8] <= wb_dat_w[15:8];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// acquisition: edges during a conversion are dropped, not queued
	assign conv_done = (state_q == ST_CONV)
		&& (conv_cnt_q == CONV_CNT_W'(CONV_CYCLES - 1));
	assign taken_next = taken_q + DEC_CNT_W'(1);
	assign acc_next = acc_q + ACC_W'(adc_sample);
	assign store_s = conv_done && (taken_next >= dec_count);

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			state_q <= ST_IDLE;
			conv_cnt_q <= '0;
		end
		else
		begin
			case (state_q)
				ST_IDLE:
				begin
					conv_cnt_q <= '0;
					if (trig_rise && trig_en)
						state_q <= ST_CONV;
				end
				ST_CONV:
				begin
					if (conv_done)
					begin
						conv_cnt_q <= '0;
						if (store_s || !burst)
							state_q <= ST_IDLE; // see (R2)
						else
							state_q <= ST_CONV; // see (R3)
					end
					else
						conv_cnt_q <= conv_cnt_q + CONV_CNT_W'(1);
				end
				default:
				begin
					state_q <= ST_IDLE;
					conv_cnt_q <= '0;
				end
			endcase
		end
	end

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			acc_q <= '0;
			taken_q <= '0;
		end
		else if (store_s)
		begin
			acc_q <= '0;
			taken_q <= '0;
		end
		else if (conv_done)
		begin
			acc_q <= acc_next;
			taken_q <= taken_next;
		end
	end

	// result goes to the axis register or to the buffer port
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			result_q <= 12'h000;
			buf_wr_q <= 1'b0;
			buf_data_q <= 12'h000;
		end
		else
		begin
			buf_wr_q <= store_s && (buf_mode != BUF_MODE_DIRECT);
			if (store_s && buf_mode == BUF_MODE_DIRECT)
				result_q <= SAMPLE_W'(acc_next >> dec_log);
			if (store_s && buf_mode != BUF_MODE_DIRECT)
				buf_data_q <= SAMPLE_W'(acc_next >> dec_log);
		end
	end

	// set wins over the clear by a result read
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			drdy_q <= 1'b0;
		else
			drdy_q <= (store_s && buf_mode == BUF_MODE_DIRECT)
				|| (drdy_q && !rd_result_s); // see (R5) (R6)
	end

	////////////////////////////////////////////////////////////////////////
	// the within-threshold event outranks a sleep request
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			sleep_q <= 1'b0;
		else if (cfg_q[WAKE_WITHIN_BIT] && within_thresh_event)
			sleep_q <= 1'b0; // see (R8)
		else if (sleep_request)
			sleep_q <= 1'b1;
		else if (wake_request)
			sleep_q <= 1'b0;
	end

	assign wb_ack = ack_q;
	assign wb_dat_r = dat_r_q;
	assign config_out = cfg_q;
	assign axis_result = result_q;
	assign data_ready_flag = drdy_q;
	assign buf_wr = buf_wr_q;
	assign buf_data = buf_data_q;
	assign sleep_state = sleep_q;
	assign conv_busy = state_q == ST_CONV;

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	property p_cfg_write;
		wr_s && wb_adr == CFG4_ADDR && wb_sel[0] |=> cfg_q == $past(wb_dat_w[7:0]);
	endproperty
	a_cfg_write: assert property (p_cfg_write) else $error("cfg write lost"); // see (R1)

	property p_single_conv;
		conv_done && !burst |=> state_q == ST_IDLE;
	endproperty
	a_single_conv: assert property (p_single_conv) else $error("extra conversion"); // see (R2)

	sequence s_burst_step;
		conv_done && burst && !store_s;
	endsequence
	property p_burst;
		s_burst_step |=> state_q == ST_CONV ##1 conv_cnt_q == CONV_CNT_W'(1);
	endproperty
	a_burst: assert property (p_burst) else $error("burst stopped early"); // see (R3)

	property p_no_trig;
		state_q == ST_IDLE && trig_rise && !trig_en |=> state_q == ST_IDLE;
	endproperty
	a_no_trig: assert property (p_no_trig) else $error("trigger not gated"); // see (R4)

	property p_ready_cause;
		$rose(drdy_q) |-> $past(store_s) && $past(taken_next) >= $past(dec_count);
	endproperty
	a_ready_cause: assert property (p_ready_cause) else $error("early ready"); // see (R5)

	property p_ready_bufmode;
		store_s && buf_mode != BUF_MODE_DIRECT && !drdy_q |=> !drdy_q && buf_wr_q;
	endproperty
	a_ready_bufmode: assert property (p_ready_bufmode) else $error("ready in buffer mode"); // see (R6)

	property p_low_power;
		pm == PM_LOW |-> dec_count == DEC_CNT_W'(1) && !burst;
	endproperty
	a_low_power: assert property (p_low_power) else $error("decimation not 1"); // see (R7)

	property p_wake;
		cfg_q[WAKE_WITHIN_BIT] && within_thresh_event |=> !sleep_q;
	endproperty
	a_wake: assert property (p_wake) else $error("sleep not blocked"); // see (R8)

	property p_dec_high;
		pm == PM_HIGH && ctrl_q[ODR_LO +: 4] < 4'hc |-> dec_log == ctrl_q[ODR_LO +: 4];
	endproperty
	a_dec_high: assert property (p_dec_high) else $error("bad decimation"); // see (R9)

	property p_edge_pulse;
		trig_rise |=> !trig_rise;
	endproperty
	a_edge_pulse: assert property (p_edge_pulse) else $error("edge too long"); // see (R10)

	property p_ack;
		wb_cyc && wb_stb && !ack_q |=> ack_q ##1 !ack_q;
	endproperty
	a_ack: assert property (p_ack) else $error("bad ack timing");
endmodule : trigger_acq_and_wake_source_config
`default_nettype wire

// *** trig_acq_pkg.sv ***
package trig_acq_pkg;
	// register byte addresses
	localparam logic [7:0] CTRL_ADDR = 8'h00;
	localparam logic [7:0] STATUS_ADDR = 8'h04;
	localparam logic [7:0] RESULT_ADDR = 8'h08;
	localparam logic [7:0] CFG4_ADDR = 8'h18;
	localparam logic [7:0] CFG4_RESET = 8'h01;
	localparam logic [15:0] CTRL_RESET = 16'h0000;
	// sensor_config_four bit positions
	localparam int TRIG_ACQ_MODE_BIT = 7;
	localparam int WAKE_WITHIN_BIT = 6;
	localparam int WAKE_OUTSIDE_BIT = 5;
	localparam int WAKE_SRC_ORIENTATION_BIT = 4;
	localparam int READY_PULSE_BIT = 3;
	localparam int IRQ2_FUNC_BIT = 2;
	localparam int IRQ_DRIVE_BIT = 1;
	localparam int IRQ_POL_BIT = 0;
	// control register fields
	localparam int PM_LO = 0;
	localparam int BUF_MODE_LO = 4;
	localparam int ODR_LO = 8;
	localparam int FLEX_DEC_LO = 12;
	// status register bits
	localparam int ST_READY_BIT = 0;
	localparam int ST_SLEEP_BIT = 1;
	localparam int ST_BUSY_BIT = 2;
	// power modes and buffer mode
	localparam logic [1:0] PM_LOW = 2'h0;
	localparam logic [1:0] PM_HIGH = 2'h1;
	localparam logic [1:0] PM_FLEX = 2'h2;
	localparam logic [1:0] BUF_MODE_DIRECT = 2'h0;
	localparam logic [3:0] DEC_LOG_MAX = 4'hc;
	// timing
	localparam int CLOCK_MHZ = 250;
	localparam int CONV_TIME_NS = 312500;
	localparam int CONV_CYCLES_DEF = (CONV_TIME_NS * CLOCK_MHZ + 999) / 1000;
	localparam int CONV_CNT_W = 17;
	localparam int DEC_CNT_W = 13;
	localparam int ACC_W = 24;
	localparam int SAMPLE_W = 12;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_CONV = 2'b10
	} acq_state_type;
endpackage : trig_acq_pkg

// *** trig_edge_sync.sv ***
`timescale 1ns/1ns
`default_nettype none
module trig_edge_sync
(
	input wire logic clock,
	input wire logic rst,
	input wire logic trig_pin,
	output logic trig_rise
);
	logic sync1_q;
	logic sync2_q;
	logic prev_q;
	logic rise_q;

	// two stages before anything looks at the pin
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
		end
		else
		begin
			sync1_q <= trig_pin;
			sync2_q <= sync1_q;
		end
	end

	// single-cycle rising edge event
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			prev_q <= 1'b0;
			rise_q <= 1'b0;
		end
		else
		begin
			prev_q <= sync2_q;
			rise_q <= sync2_q & ~prev_q; // see (R10)
		end
	end

	assign trig_rise = rise_q;
endmodule : trig_edge_sync
`default_nettype wire

// *** trig_host_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module trig_host_model
(
	input wire logic clock,
	input wire logic fire,
	output logic trig_pin
);
	int hold_q = 0;
	// held four cycles so the input synchroniser cannot miss it
	always_ff @(posedge clock)
	begin
		if (fire)
			hold_q <= 4;
		else if (hold_q > 0)
			hold_q <= hold_q - 1;
	end
	assign trig_pin = (hold_q > 0);
endmodule : trig_host_model
`default_nettype wire

// *** tb_top.sv ***
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	import trig_acq_pkg::*;
	logic clock = 0, rst = 1, wb_cyc = 0, wb_stb = 0, wb_we = 0, fire = 0;
	logic within_thresh_event = 0, sleep_request = 0, wake_request = 0;
	logic [7:0] wb_adr = 0, config_out;
	logic [3:0] wb_sel = 0;
	logic [31:0] wb_dat_w = 0, wb_dat_r, rd;
	logic [11:0] adc_sample = 0, axis_result, buf_data;
	logic wb_ack, trig_pin, data_ready_flag, buf_wr, sleep_state, conv_busy;
	logic wr_seen = 0;
	int errors = 0, n_checks = 0, cycles = 0;
	int md[6] = '{0, 1, 1, 0, 1, 1};
	logic [1:0] pmv[6] = '{PM_HIGH, PM_HIGH, PM_FLEX, PM_LOW, PM_HIGH, PM_HIGH};
	int cd[6] = '{2, 2, 1, 3, 1, 1};
	int bm[6] = '{0, 0, 0, 0, 1, 0};
	int fn[6] = '{1, 1, 1, 1, 1, 0};

	trigger_acq_and_wake_source_config #(.CONV_CYCLES(8)) i_dut
	(
		.clock(clock), .rst(rst), .wb_cyc(wb_cyc), .wb_stb(wb_stb),
		.wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel),
		.wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r), .wb_ack(wb_ack),
		.trig_pin(trig_pin), .adc_sample(adc_sample),
		.within_thresh_event(within_thresh_event),
		.sleep_request(sleep_request), .wake_request(wake_request),
		.config_out(config_out), .axis_result(axis_result),
		.data_ready_flag(data_ready_flag), .buf_wr(buf_wr),
		.buf_data(buf_data), .sleep_state(sleep_state), .conv_busy(conv_busy)
	);
	trig_host_model i_host (.clock(clock), .fire(fire), .trig_pin(trig_pin));

	initial
	begin
		forever #2 clock = ~clock;
	end

	task automatic close_out();
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : close_out

	always @(posedge clock)
	begin
		cycles <= cycles + 1;
		if (buf_wr === 1'b1)
			wr_seen <= 1;
		if (cycles == 20000)
		begin
			errors++;
			close_out();
		end
	end

	task automatic check(input string nm, input logic [31:0] seen,
		input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check

	// one classic cycle; waits for ack, then one idle cycle
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
		wb_cyc <= 1;
		wb_stb <= 1;
		wb_we <= we;
		wb_adr <= a;
		wb_dat_w <= d;
		wb_sel <= 4'b0011;
		@(posedge clock);
		while (wb_ack !== 1'b1)
			@(posedge clock);
		rd = wb_dat_r;
		wb_cyc <= 0;
		wb_stb <= 0;
		wb_we <= 0;
		@(posedge clock);
	endtask : wb

	task automatic pulse_trig();
		int t;
		t = 0;
		fire <= 1;
		@(posedge clock);
		fire <= 0;
		while (conv_busy !== 1'b1 && t < 12)
		begin
			@(posedge clock);
			t++;
		end
		while (conv_busy === 1'b1 && t < 400)
		begin
			@(posedge clock);
			t++;
		end
		repeat (2) @(posedge clock);
	endtask : pulse_trig

	function automatic int dec_of(input logic [1:0] pm, input int code);
		if (pm == PM_HIGH || pm == PM_FLEX)
			return 1 << ((code > 12) ? 12 : code);
		return 1;
	endfunction : dec_of

	initial
	begin
		int seed;
		int n;
		logic [31:0] v;
		logic [3:0] odr, fdec;
		logic exp_rdy;
		seed = $urandom(83798);
		repeat (6) @(posedge clock);
		rst <= 0;
		@(posedge clock);
		check("cfg out reset", 32'(config_out), 32'(CFG4_RESET));
		wb(0, CFG4_ADDR, 0);
		check("cfg read reset", rd, 32'(CFG4_RESET));
		v = $urandom;
		wb(1, CFG4_ADDR, v);
		wb(0, CFG4_ADDR, 0);
		check("cfg read back", rd, 32'(v[7:0]));
		check("cfg out", 32'(config_out), 32'(v[7:0]));
		wb(1, 8'h3c, 32'hffff_ffff);
		wb(0, 8'h3c, 0);
		check("unmapped", rd, 0);
		for (int i = 0; i < 6; i++)
		begin
			n = (md[i] == 1) ? 1 : dec_of(pmv[i], cd[i]);
			// the unused field is set off-target to expose a mix-up
			odr = (pmv[i] == PM_FLEX) ? 4'h3 : 4'(cd[i]);
			fdec = (pmv[i] == PM_FLEX) ? 4'(cd[i]) : 4'h3;
			wb(1, CTRL_ADDR, {16'h0, fdec, odr, 2'h0, 2'(bm[i]), 2'h0, pmv[i]});
			wb(1, CFG4_ADDR, 32'({1'(md[i]), 4'h0, 1'(fn[i]), 2'h0}));
			wb(0, RESULT_ADDR, 0);
			v = $urandom;
			adc_sample <= v[11:0];
			wr_seen <= 0;
			for (int k = 1; k <= n; k++)
			begin
				pulse_trig();
				if (k < n)
					check("early ready", 32'(data_ready_flag), 0);
			end
			exp_rdy = (fn[i] == 1 && bm[i] == 0);
			check("ready", 32'(data_ready_flag), 32'(exp_rdy));
			check("buf write", 32'(wr_seen), 32'(fn[i] == 1 && bm[i] != 0));
			if (bm[i] != 0)
				check("buf data", 32'(buf_data), 32'(v[11:0]));
			if (exp_rdy)
			begin
				check("result", 32'(axis_result), 32'(v[11:0]));
				wb(0, RESULT_ADDR, 0);
				check("result reg", rd, 32'(v[11:0]));
				check("ready cleared", 32'(data_ready_flag), 0);
			end
		end
		wb(1, CFG4_ADDR, 32'h0000_0040);
		sleep_request <= 1;
		repeat (3) @(posedge clock);
		check("sleep entry", 32'(sleep_state), 1);
		within_thresh_event <= 1;
		repeat (3) @(posedge clock);
		check("within forces wake", 32'(sleep_state), 0);
		within_thresh_event <= 0;
		wb(1, CFG4_ADDR, 0);
		repeat (3) @(posedge clock);
		within_thresh_event <= 1;
		repeat (3) @(posedge clock);
		check("within ignored", 32'(sleep_state), 1);
		within_thresh_event <= 0;
		sleep_request <= 0;
		wake_request <= 1;
		repeat (3) @(posedge clock);
		check("other wake", 32'(sleep_state), 0);
		close_out();
	end
endmodule : tb_top
`default_nettype wire
